// ==== rws_ctrl.sv ====
/*
 * Reset, watchdog and suspend controller of a small USB microcontroller.
 * Assumes the core I/O port on sys_clk, analogue detectors on pins.
 */
// What this block does
// - supply resets set status bit 4, watchdog resets set status bit 6
// - after any reset fetch starts at 0x0000 with nothing pushed
// - reset clears all registers except status, which takes its reset values
// - reset floats pins and regulator pin, disables interrupts and USB
// - supply resets force internal clock, then wait the start-up period
// - watchdog reset keeps clock mode, no settle delay, clears oscillator bit
// - reset loads both stack pointers with 0x00
// - power-up enables supply reset, start-up counter runs once supply is good
// - while enabled, every low-supply indication repeats the full sequence
// - low-supply reset off in suspend, back afterwards if it was enabled
// - sag detector always active, sole detector when low-supply reset off
// - after sag, hold until supply above threshold, then start-up delay
// - any write to 0x26 clears watchdog, rollover gives watchdog reset
// - watchdog reset held 2 ms, then fetch from 0x0000
// - suspend stops oscillators, free-running timer and watchdog
// - wake only on enabled interrupts or low bus-minus pin
// - resume after oscillator stable and mode-dependent delay expires
// - suspend wake ignores the global interrupt enable sense bit
// - suspend entered even when a wake condition already exists
// - resume only when the run bit is set
// - after resume, next instruction runs before any interrupt service
// - clock configuration bit 3 set disables low-supply reset
// - external mode resume delay is 128 us or 4 ms by bit 7
// - internal mode resume waits 8 us after oscillator start
// - wake clock mode chosen by clock configuration bit 0
`timescale 1ns/1ps
`default_nettype none
`include "rws_params.svh"

module rws_ctrl #(
	parameter int START_CYC     = `RWS_START_CYC,
	parameter int WATCH_CYC     = `RWS_WATCH_CYC,
	parameter int WDT_HOLD_CYC  = `RWS_WDT_HOLD_CYC,
	parameter int EXT_SHORT_CYC = `RWS_EXT_SHORT_CYC,
	parameter int EXT_LONG_CYC  = `RWS_EXT_LONG_CYC
) (
	input  wire logic               sys_clk,            // 200 MHz clock
	input  wire logic               sys_rst,            // power applied, high
	input  wire logic [7:0]         io_addr,            // core I/O address
	input  wire logic [7:0]         io_wdata,           // core write data
	input  wire logic               io_wr,              // write strobe
	input  wire logic               io_rd,              // read strobe
	input  wire logic               core_instr_done,    // instruction retired
	input  wire rws_pkg::rws_wake_t wake_req,           // enabled+pending irqs
	input  wire logic               supply_ok_pin,      // above threshold
	input  wire logic               sag_trip_pin,       // sag detector tripped
	input  wire logic               osc_stable_pin,     // ext oscillator stable
	input  wire logic               bus_minus_data_pin, // bus-minus level
	output logic [7:0]              io_rdata_q,         // read data
	output logic                    core_rst_q,         // core held in reset
	output logic                    core_halt_q,        // core clock gated
	output logic                    restart_pulse_q,    // fetch from vector
	output logic [15:0]             restart_addr_q,     // fetch address
	output rws_pkg::rws_rst_fx_t    rst_fx_q,           // reset effects
	output logic                    int_osc_en_q,       // internal osc on
	output logic                    ext_osc_en_q,       // external osc on
	output logic                    timers_run_q,       // timers clocked
	output logic                    lvr_active_q,       // low-supply reset armed
	output logic                    irq_defer_q         // hold off interrupts
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	rws_pkg::rws_state_t state_q;
	rws_pkg::rws_state_t state_d;
	logic [3:0]          s1_q;
	logic [3:0]          s2_q;
	logic [3:0]          s3_q;
	logic [3:0]          pin_q;
	logic [7:0]          status_q;
	logic [7:0]          cfg_q;
	logic                ext_mode_q;
	logic                ext_mode_d;
	logic [23:0]         wdt_cnt_q;
	logic                tmr_load;
	logic [23:0]         tmr_val;
	logic                tmr_done;
	logic                supply_ok_s;
	logic                sag_s;
	logic                osc_ok_s;
	logic                bus_minus_s;
	logic                wr_status;
	logic                wr_cfg;
	logic                wr_wdt;
	logic                lvr_en;
	logic                supply_trip;
	logic                supply_evt;
	logic                wdt_roll;
	logic                wdt_evt;
	logic                susp_req;
	logic                ext_switch;
	logic                wake;
	logic                resume_end;
	logic                in_reset_d;

	// address match on a core read or write
	function automatic logic io_hit(input logic [7:0] addr, input logic [7:0] tgt);
		io_hit = (addr == tgt);
	endfunction : io_hit

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// three stages; a change counts once stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s1_q  <= `RWS_PIN_RST;
			s2_q  <= `RWS_PIN_RST;
			s3_q  <= `RWS_PIN_RST;
			pin_q <= `RWS_PIN_RST;
		end else begin
			s1_q  <= {bus_minus_data_pin, osc_stable_pin, sag_trip_pin, supply_ok_pin};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			pin_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
		end
	end

	assign supply_ok_s = pin_q[0];
	assign sag_s       = pin_q[1];
	assign osc_ok_s    = pin_q[2];
	assign bus_minus_s = pin_q[3];

	// ------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------
	// status and configuration writes only land while the core runs
	assign wr_status = io_wr && io_hit(io_addr, `RWS_ADDR_STATUS) && state_q == rws_pkg::ST_RUN;
	assign wr_cfg    = io_wr && io_hit(io_addr, `RWS_ADDR_CLK_CFG) && state_q == rws_pkg::ST_RUN;
	assign wr_wdt    = io_wr && io_hit(io_addr, `RWS_ADDR_WDT_CLR);

	// low-supply detector armed while bit 3 is clear, never in suspend
	assign lvr_en = !cfg_q[`RWS_CFG_LVR_DIS] && state_q != rws_pkg::ST_SUSPEND;

	// sag detector always counts, low-supply only when armed
	assign supply_trip = (lvr_en && !supply_ok_s) || sag_s;
	assign supply_evt  = supply_trip && state_q != rws_pkg::ST_POWER_HOLD;

	// watchdog rollover while running
	assign wdt_roll = state_q == rws_pkg::ST_RUN && wdt_cnt_q == 24'(WATCH_CYC - 1);
	assign wdt_evt  = wdt_roll && !supply_trip;

	// suspend request: suspend bit written, wake state irrelevant
	assign susp_req = wr_status && io_wdata[`RWS_ST_SUSPEND];

	// firmware switches a running core to the external oscillator
	assign ext_switch = wr_cfg && io_wdata[`RWS_CFG_EXT_OSC] && !ext_mode_q;

	// wake sources, interrupt sense bit not consulted
	assign wake = status_q[`RWS_ST_RUN] && (|wake_req || !bus_minus_s);

	assign resume_end = state_q == rws_pkg::ST_RESUME && tmr_done;

	// ------------------------------------------------------------
	// delay timer
	// ------------------------------------------------------------
	rws_delay_timer u_delay (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.load     (tmr_load),
		.load_val (tmr_val),
		.busy_q   (),
		.done_q   (tmr_done)
	);

	// ------------------------------------------------------------
	// next state and delay selection
	// ------------------------------------------------------------
	always_comb begin
		state_d  = state_q;
		tmr_load = 1'b0;
		tmr_val  = 24'h000000;
		if (supply_trip) begin
			state_d = rws_pkg::ST_POWER_HOLD;
		end else begin
			unique case (state_q)
				rws_pkg::ST_POWER_HOLD: begin
					if (supply_ok_s) begin
						state_d  = rws_pkg::ST_START;
						tmr_load = 1'b1;
						tmr_val  = 24'(START_CYC);
					end
				end
				rws_pkg::ST_START: begin
					if (tmr_done) begin
						state_d = rws_pkg::ST_RUN;
					end
				end
				rws_pkg::ST_RUN: begin
					if (wdt_roll) begin
						state_d  = rws_pkg::ST_WDT_HOLD;
						tmr_load = 1'b1;
						tmr_val  = 24'(WDT_HOLD_CYC);
					end else if (susp_req) begin
						state_d = rws_pkg::ST_SUSPEND;
					end else if (ext_switch) begin
						state_d = rws_pkg::ST_OSC_WAIT;
					end
				end
				rws_pkg::ST_WDT_HOLD: begin
					if (tmr_done) begin
						state_d = rws_pkg::ST_RUN;
					end
				end
				rws_pkg::ST_SUSPEND: begin
					if (wake && cfg_q[`RWS_CFG_EXT_OSC]) begin
						state_d = rws_pkg::ST_OSC_WAIT;
					end else if (wake) begin
						state_d  = rws_pkg::ST_RESUME;
						tmr_load = 1'b1;
						tmr_val  = 24'(`RWS_INT_RESUME_CYC);
					end
				end
				rws_pkg::ST_OSC_WAIT: begin
					if (osc_ok_s) begin
						state_d  = rws_pkg::ST_RESUME;
						tmr_load = 1'b1;
						tmr_val  = cfg_q[`RWS_CFG_EXT_DLY] ? 24'(EXT_LONG_CYC)
						                                   : 24'(EXT_SHORT_CYC);
					end
				end
				rws_pkg::ST_RESUME: begin
					if (tmr_done) begin
						state_d = rws_pkg::ST_RUN;
					end
				end
				default: begin
					state_d = rws_pkg::ST_POWER_HOLD;
				end
			endcase
		end
	end

	// clock mode that the next state runs in
	always_comb begin
		ext_mode_d = ext_mode_q;
		if (supply_evt) begin
			ext_mode_d = 1'b0;
		end else if (state_q == rws_pkg::ST_SUSPEND && wake) begin
			ext_mode_d = cfg_q[`RWS_CFG_EXT_OSC];
		end else if (state_q == rws_pkg::ST_RUN && state_d == rws_pkg::ST_OSC_WAIT) begin
			ext_mode_d = 1'b1;
		end
	end

	assign in_reset_d = state_d == rws_pkg::ST_POWER_HOLD || state_d == rws_pkg::ST_START ||
	                    state_d == rws_pkg::ST_WDT_HOLD;

	// ------------------------------------------------------------
	// state and clock mode
	// ------------------------------------------------------------
	// power-up lands in the supply hold with detectors armed
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q    <= rws_pkg::ST_POWER_HOLD;
			ext_mode_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			ext_mode_q <= ext_mode_d;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// status: reset values plus sticky cause bits; set beats clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status_q <= `RWS_STATUS_POR;
		end else if (supply_evt || wdt_evt) begin
			status_q <= `RWS_STATUS_RST | (status_q & `RWS_CAUSE_MASK);
			status_q[`RWS_ST_SUPPLY_CAUSE] <= status_q[`RWS_ST_SUPPLY_CAUSE] || supply_evt;
			status_q[`RWS_ST_WDT_CAUSE]    <= status_q[`RWS_ST_WDT_CAUSE] || wdt_evt;
		end else if (wr_status) begin
			status_q <= (io_wdata & ~`RWS_CAUSE_MASK) | (io_wdata & status_q & `RWS_CAUSE_MASK);
		end else if (resume_end) begin
			status_q[`RWS_ST_SUSPEND] <= 1'b0;
		end
	end

	// clock configuration: cleared by every reset kind
	always_ff @(posedge sys_clk) begin
		if (sys_rst || supply_evt || wdt_evt) begin
			cfg_q <= `RWS_CFG_RST;
		end else if (wr_cfg) begin
			cfg_q <= io_wdata;
		end
	end

	// watchdog: cleared by write or reset, frozen outside run
	always_ff @(posedge sys_clk) begin
		if (sys_rst || wr_wdt || wdt_roll || in_reset_d) begin
			wdt_cnt_q <= 24'h000000;
		end else if (state_q == rws_pkg::ST_RUN) begin
			wdt_cnt_q <= wdt_cnt_q + 24'h000001;
		end
	end

	// read port; watchdog clear is write-only and reads zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			io_rdata_q <= 8'h00;
		end else if (io_rd) begin
			if (io_hit(io_addr, `RWS_ADDR_STATUS)) begin
				io_rdata_q <= status_q;
			end else if (io_hit(io_addr, `RWS_ADDR_CLK_CFG)) begin
				io_rdata_q <= cfg_q;
			end else begin
				io_rdata_q <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// core and chip controls
	// ------------------------------------------------------------
	// reset hold, halt and restart towards the core
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			core_rst_q      <= 1'b1;
			core_halt_q     <= 1'b1;
			restart_pulse_q <= 1'b0;
			restart_addr_q  <= `RWS_RESET_VECTOR;
		end else begin
			core_rst_q      <= in_reset_d;
			core_halt_q     <= state_d != rws_pkg::ST_RUN;
			restart_pulse_q <= core_rst_q && !in_reset_d;
			restart_addr_q  <= `RWS_RESET_VECTOR;
		end
	end

	// pins float, interrupts and USB off, stacks zeroed in reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rst_fx_q <= '1;
		end else begin
			rst_fx_q.regs_clear  <= in_reset_d;
			rst_fx_q.pins_hiz    <= in_reset_d;
			rst_fx_q.reg_pin_hiz <= in_reset_d;
			rst_fx_q.irq_off     <= in_reset_d;
			rst_fx_q.usb_off     <= in_reset_d;
			rst_fx_q.stack_zero  <= in_reset_d;
		end
	end

	// oscillators, timers and detector arming
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			int_osc_en_q <= 1'b1;
			ext_osc_en_q <= 1'b0;
			timers_run_q <= 1'b0;
			lvr_active_q <= 1'b1;
		end else begin
			int_osc_en_q <= state_d != rws_pkg::ST_SUSPEND && !ext_mode_d;
			ext_osc_en_q <= state_d != rws_pkg::ST_SUSPEND && ext_mode_d;
			timers_run_q <= state_d == rws_pkg::ST_RUN;
			lvr_active_q <= !cfg_q[`RWS_CFG_LVR_DIS] && state_d != rws_pkg::ST_SUSPEND;
		end
	end

	// one instruction runs after resume before interrupts; set wins
	always_ff @(posedge sys_clk) begin
		if (sys_rst || in_reset_d) begin
			irq_defer_q <= 1'b0;
		end else if (resume_end && status_q[`RWS_ST_SUSPEND]) begin
			irq_defer_q <= 1'b1;
		end else if (core_instr_done) begin
			irq_defer_q <= 1'b0;
		end
	end

endmodule : rws_ctrl

`default_nettype wire

// ==== rws_ctrl_assertions.sv ====
/* concurrent checks on the ports of rws_ctrl, bound to every instance.
   assumes one clock sys_clk and a synchronous active-high sys_rst. */
`timescale 1ns/1ps
`default_nettype none

module rws_ctrl_assertions (
	input wire logic               sys_clk,            // clock
	input wire logic               sys_rst,            // sync reset
	input wire logic [7:0]         io_addr,            // address
	input wire logic [7:0]         io_wdata,           // write data
	input wire logic               io_wr,              // write strobe
	input wire logic               io_rd,              // read strobe
	input wire logic               core_instr_done,    // retired
	input wire rws_pkg::rws_wake_t wake_req,           // wake requests
	input wire logic               supply_ok_pin,      // supply good
	input wire logic               sag_trip_pin,       // sag trip
	input wire logic               osc_stable_pin,     // osc stable
	input wire logic               bus_minus_data_pin, // bus-minus level
	input wire logic [7:0]         io_rdata_q,         // read data
	input wire logic               core_rst_q,         // core reset
	input wire logic               core_halt_q,        // core halted
	input wire logic               restart_pulse_q,    // restart
	input wire logic [15:0]        restart_addr_q,     // fetch address
	input wire rws_pkg::rws_rst_fx_t rst_fx_q,         // reset effects
	input wire logic               int_osc_en_q,       // internal osc
	input wire logic               ext_osc_en_q,       // external osc
	input wire logic               timers_run_q,       // timers clocked
	input wire logic               lvr_active_q,       // low-supply armed
	input wire logic               irq_defer_q         // irq hold-off
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// suspend write taken while running, then everything asleep
	sequence suspend_wr;
		io_wr && io_addr == 8'hFF && io_wdata == 8'h09 && !core_halt_q;
	endsequence
	sequence asleep;
		core_halt_q && !timers_run_q && !int_osc_en_q && !ext_osc_en_q && !lvr_active_q;
	endsequence

	AST_SUSPEND_ENTRY: assert property (suspend_wr |=> asleep)
		else $error("suspend entry left a clock or detector on");
	AST_VECTOR: assert property (restart_addr_q == 16'h0000)
		else $error("restart address not zero");
	AST_PULSE: assert property (restart_pulse_q |=> !restart_pulse_q)
		else $error("restart pulse longer than one cycle");
	AST_RESTART: assert property ($fell(core_rst_q) |-> ##[0:2] restart_pulse_q)
		else $error("no restart pulse after reset release");
	AST_RST_FX: assert property (core_rst_q |-> rst_fx_q == 6'h3F)
		else $error("reset effects not all applied");
	AST_RST_HOLD: assert property ($rose(core_rst_q) |-> core_rst_q [*8])
		else $error("reset released too early");
	AST_TIMERS: assert property (timers_run_q |-> !core_halt_q && !core_rst_q)
		else $error("timers clocked while halted");
	AST_DEFER: assert property (irq_defer_q && !core_instr_done && !core_rst_q |=> irq_defer_q || core_rst_q)
		else $error("interrupt hold-off dropped early");
	AST_WDT_READ: assert property (io_rd && io_addr == 8'h26 |=> io_rdata_q == 8'h00)
		else $error("watchdog clear register not write-only");
endmodule : rws_ctrl_assertions

bind rws_ctrl rws_ctrl_assertions u_rws_ctrl_assertions (.sys_clk, .sys_rst, .io_addr,
	.io_wdata, .io_wr, .io_rd, .core_instr_done, .wake_req, .supply_ok_pin, .sag_trip_pin,
	.osc_stable_pin, .bus_minus_data_pin, .io_rdata_q, .core_rst_q, .core_halt_q,
	.restart_pulse_q, .restart_addr_q, .rst_fx_q, .int_osc_en_q, .ext_osc_en_q,
	.timers_run_q, .lvr_active_q, .irq_defer_q);

`default_nettype wire

// ==== rws_ctrl_tb.sv ====
/* self-checking bench for rws_ctrl with shortened delays.
   assumes rws_params.svh on the include path and the bound checker. */
`timescale 1ns/1ps
`default_nettype none

module rws_ctrl_tb;
	logic               sys_clk, sys_rst, io_wr, io_rd, core_instr_done;
	logic               supply_ok_pin, sag_trip_pin, osc_stable_pin, bus_minus_data_pin;
	logic [7:0]         io_addr, io_wdata, io_rdata_q, a;
	rws_pkg::rws_wake_t wake_req;
	rws_pkg::rws_rst_fx_t rst_fx_q;
	logic               core_rst_q, core_halt_q, restart_pulse_q, int_osc_en_q;
	logic               ext_osc_en_q, timers_run_q, lvr_active_q, irq_defer_q;
	logic [15:0]        restart_addr_q;
	int                 n_mismatch, n_checks, seed, n, i;

	rws_ctrl #(.START_CYC(20), .WATCH_CYC(50), .WDT_HOLD_CYC(10), .EXT_SHORT_CYC(8),
		.EXT_LONG_CYC(16)) u_rws_ctrl (.sys_clk, .sys_rst, .io_addr, .io_wdata, .io_wr,
		.io_rd, .core_instr_done, .wake_req, .supply_ok_pin, .sag_trip_pin, .osc_stable_pin,
		.bus_minus_data_pin, .io_rdata_q, .core_rst_q, .core_halt_q, .restart_pulse_q,
		.restart_addr_q, .rst_fx_q, .int_osc_en_q, .ext_osc_en_q, .timers_run_q,
		.lvr_active_q, .irq_defer_q);

	// 200 MHz clock
	initial begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// resume delay in cycles for a clock configuration value
	function automatic int resume_cyc(input logic [7:0] c);
		return c[0] ? (c[7] ? 16 : 8) : 8 * 200;
	endfunction : resume_cyc

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task chk_rng(input int g, input int lo, input int hi);
		n_checks++;
		if (g < lo || g > hi) begin
			n_mismatch++;
			$display("wrong value t=%0t got %h exp %h", $time, g, lo);
		end
	endtask : chk_rng

	task cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : cyc

	task wr(input logic [7:0] ad, input logic [7:0] d);
		cyc(1);
		io_addr = ad;
		io_wdata = d;
		io_wr = 1;
		cyc(1);
		io_wr = 0;
	endtask : wr

	task rd(input logic [7:0] ad, input logic [7:0] e);
		cyc(1);
		io_addr = ad;
		io_rd = 1;
		cyc(1);
		io_rd = 0;
		chk(io_rdata_q, e);
	endtask : rd

	// bounded wait for halt (s=0) or reset (s=1) to reach v
	task wt(input int s, input logic v, output int k);
		k = 0;
		while (((s == 0) ? core_halt_q : core_rst_q) !== v && k < 5000) begin
			cyc(1);
			k++;
		end
		if (k >= 5000) begin
			n_mismatch++;
			$display("wrong value t=%0t got %h exp %h", $time, k, v);
			report_and_stop;
		end
	endtask : wt

	// main sequence
	initial begin
		seed = 56; n_mismatch = 0; n_checks = 0;
		sys_rst = 1; io_wr = 0; io_rd = 0; io_addr = 8'h00; io_wdata = 8'h00;
		core_instr_done = 0; wake_req = 3'h0; supply_ok_pin = 1; sag_trip_pin = 0;
		osc_stable_pin = 1; bus_minus_data_pin = 1;
		repeat (12) @(posedge sys_clk);
		#1 sys_rst = 0;
		wt(1, 0, n);
		chk(lvr_active_q, 1'b1);
		rd(8'hFF, 8'h11);
		repeat (6) begin
			a = 8'($random(seed));
			if (a == 8'hFF || a == 8'hF8) a = 8'h26;
			rd(a, 8'h00);
		end
		wr(8'hFF, 8'h01);
		wr(8'hF8, 8'h01);
		cyc(2);
		wt(0, 0, n);
		chk(ext_osc_en_q, 1'b1);
		// random watchdog kicks, then let it roll over
		wr(8'h26, 8'h00);
		repeat (5) begin
			cyc(10 + ($random(seed) & 31));
			wr(8'h26, 8'($random(seed)));
		end
		chk(core_rst_q, 1'b0);
		wt(1, 1, n);
		chk_rng(n, 48, 56);
		wt(1, 0, n);
		chk_rng(n, 10, 14);
		chk(ext_osc_en_q, 1'b1);
		rd(8'hFF, 8'h41);
		rd(8'hF8, 8'h00);
		// internal-clock wake from each source, last one present before entry
		for (i = 0; i < 5; i++) begin
			a = (i == 2) ? 8'h0D : 8'h09;
			if (i == 4) wake_req = 3'h4;
			wr(8'hFF, a);
			chk(core_halt_q, 1'b1);
			chk(lvr_active_q, 1'b0);
			if (i < 4) begin
				cyc(20);
				chk(core_halt_q, 1'b1);
				wake_req = (i < 3) ? (3'h4 >> i) : 3'h0;
				bus_minus_data_pin = (i != 3);
			end
			wt(0, 0, n);
			chk_rng(n, resume_cyc(8'h00), resume_cyc(8'h00) + 10);
			wake_req = 3'h0; bus_minus_data_pin = 1;
			chk(lvr_active_q, 1'b1);
			chk(irq_defer_q, 1'b1);
			wr(8'h26, 8'h00);
			core_instr_done = 1;
			cyc(1);
			core_instr_done = 0;
			chk(irq_defer_q, 1'b0);
			rd(8'hFF, a & 8'hF7);
		end
		// external-clock wake, both resume delays
		for (i = 0; i < 2; i++) begin
			a = {i[0], 7'h01};
			wr(8'hF8, a);
			cyc(2);
			wt(0, 0, n);
			wr(8'h26, 8'h00);
			osc_stable_pin = 0;
			wr(8'hFF, 8'h09);
			bus_minus_data_pin = 0;
			cyc(10);
			chk(core_halt_q, 1'b1);
			osc_stable_pin = 1;
			wt(0, 0, n);
			chk_rng(n, resume_cyc(a), resume_cyc(a) + 8);
			bus_minus_data_pin = 1;
			chk(ext_osc_en_q, 1'b1);
		end
		// run bit clear: no wake, sag is the only way out
		wr(8'hFF, 8'h08);
		wake_req = 3'h4;
		cyc(1700);
		chk(core_halt_q, 1'b1);
		wake_req = 3'h0; supply_ok_pin = 0;
		cyc(10);
		chk(core_rst_q, 1'b0);
		sag_trip_pin = 1;
		wt(1, 1, n);
		chk({int_osc_en_q, ext_osc_en_q}, 2'b10);
		cyc(5);
		sag_trip_pin = 0;
		cyc(30);
		chk(core_rst_q, 1'b1);
		supply_ok_pin = 1;
		wt(1, 0, n);
		chk_rng(n, 20, 32);
		rd(8'hFF, 8'h11);
		rd(8'hF8, 8'h00);
		wr(8'hF8, 8'h08);
		supply_ok_pin = 0;
		cyc(30);
		chk(core_rst_q, 1'b0);
		wr(8'hF8, 8'h00);
		wt(1, 1, n);
		chk_rng(n, 0, 8);
		supply_ok_pin = 1;
		wt(1, 0, n);
		report_and_stop;
	end
endmodule : rws_ctrl_tb

`default_nettype wire

// ==== rws_delay_timer.sv ====
/*
 * One-shot down counter for start-up, hold and resume delays.
 * Assumes load is a one-cycle pulse on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rws_delay_timer (
	input  wire logic        sys_clk,  // system clock
	input  wire logic        sys_rst,  // sync reset, high
	input  wire logic        load,     // start a new delay
	input  wire logic [23:0] load_val, // delay in cycles
	output logic             busy_q,   // delay running
	output logic             done_q    // one-cycle end pulse
);

	logic [23:0] cnt_q;

	// ------------------------------------------------------------
	// count down, pulse at the end
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_q  <= 24'h000000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (load) begin
			cnt_q  <= load_val;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end else if (busy_q && cnt_q <= 24'h000001) begin
			cnt_q  <= 24'h000000;
			busy_q <= 1'b0;
			done_q <= 1'b1;
		end else begin
			cnt_q  <= busy_q ? cnt_q - 24'h000001 : cnt_q;
			done_q <= 1'b0;
		end
	end

endmodule : rws_delay_timer

`default_nettype wire

// ==== rws_params.svh ====
/*
 * Offsets, field positions, reset values and timing constants of the
 * reset, watchdog and suspend controller.
 * Assumes a 200 MHz sys_clk; the core owns every other register.
 */
`ifndef RWS_PARAMS_SVH
`define RWS_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define RWS_ADDR_WDT_CLR    8'h26
`define RWS_ADDR_CLK_CFG    8'hF8
`define RWS_ADDR_STATUS     8'hFF

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RWS_ST_RUN          0
`define RWS_ST_IE_SENSE     2
`define RWS_ST_SUSPEND      3
`define RWS_ST_SUPPLY_CAUSE 4
`define RWS_ST_WDT_CAUSE    6
`define RWS_CFG_EXT_OSC     0
`define RWS_CFG_LVR_DIS     3
`define RWS_CFG_EXT_DLY     7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RWS_STATUS_RST      8'h01
`define RWS_STATUS_POR      8'h11
`define RWS_CAUSE_MASK      8'h50
`define RWS_CFG_RST         8'h00
`define RWS_RESET_VECTOR    16'h0000
`define RWS_PIN_RST         4'h8

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RWS_CLK_MHZ         200
`define RWS_T_INT_RESUME_US 8
`define RWS_T_EXT_SHORT_US  128
`define RWS_T_EXT_LONG_MS   4
`define RWS_T_WDT_HOLD_MS   2
`define RWS_T_START_MS      1
`define RWS_T_WATCH_MS      8
`define RWS_INT_RESUME_CYC  (`RWS_T_INT_RESUME_US * `RWS_CLK_MHZ)
`define RWS_EXT_SHORT_CYC   (`RWS_T_EXT_SHORT_US * `RWS_CLK_MHZ)
`define RWS_EXT_LONG_CYC    (`RWS_T_EXT_LONG_MS * 1000 * `RWS_CLK_MHZ)
`define RWS_WDT_HOLD_CYC    (`RWS_T_WDT_HOLD_MS * 1000 * `RWS_CLK_MHZ)
`define RWS_START_CYC       (`RWS_T_START_MS * 1000 * `RWS_CLK_MHZ)
`define RWS_WATCH_CYC       (`RWS_T_WATCH_MS * 1000 * `RWS_CLK_MHZ)

`endif

// ==== rws_pkg.sv ====
/*
 * Types shared by the reset, watchdog and suspend controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rws_pkg;

	// controller states
	typedef enum logic [2:0] {
		ST_POWER_HOLD,
		ST_START,
		ST_RUN,
		ST_WDT_HOLD,
		ST_SUSPEND,
		ST_OSC_WAIT,
		ST_RESUME
	} rws_state_t;

	// effects held on the rest of the chip while in reset
	typedef struct packed {
		logic regs_clear;
		logic pins_hiz;
		logic reg_pin_hiz;
		logic irq_off;
		logic usb_off;
		logic stack_zero;
	} rws_rst_fx_t;

	// enabled and pending wake requests from on-chip logic
	typedef struct packed {
		logic gpio_irq;
		logic wake_timer_irq;
		logic serial_irq;
	} rws_wake_t;

endpackage : rws_pkg
